//--- pkg/failover_pkg.sv
/*
 * Shared types and constants of the dual-input failover switch.
 * Assumes one 100 MHz clock drives the switch, its delay lines and its FIFO.
 */
package failover_pkg;

    localparam int CLK_PERIOD_NS = 10;
    // Holdoff timers count in steps of one millisecond.
    localparam int HOLDOFF_TICK_NS = 1000000;
    localparam int HOLDOFF_TICK_CYC = HOLDOFF_TICK_NS / CLK_PERIOD_NS;

    localparam int DATA_W = 8;
    localparam int ID_W = 16;
    localparam int HOLD_W = 16;
    localparam int DLY_W = 4;
    localparam int OFS_W = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [OFS_W-1:0] OFS_MAX = 8'hFF;
    localparam logic [DLY_W-1:0] DLY_ZERO = 4'h0;

    // Input index: 0 is logical input 1, 1 is logical input 2.
    localparam logic IN_ONE = 1'b0;
    localparam logic IN_TWO = 1'b1;

    typedef enum logic [1:0] {
        PREF_NONE = 2'b00,
        PREF_IN1 = 2'b01,
        PREF_IN2 = 2'b10
    } pref_t;

    // Direction mode: one-way changeover or both ways.
    localparam logic DIR_ONE_WAY = 1'b0;
    localparam logic DIR_BOTH = 1'b1;

    typedef enum logic [1:0] {
        AUTO_OFF = 2'b00,
        AUTO_ACTIVE = 2'b01,
        AUTO_CHANGED = 2'b10
    } auto_state_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } word_t;

    localparam int WORD_W = DATA_W + 1;

endpackage

//--- core/failover_switch.sv
/*
 * Failover controller for two logical transport-stream inputs, with the
 * alignment delay lines and the output FIFO in the same file.
 * Assumes the input interfaces and the operator settings are synchronous
 * to CLK, and that stream sources hold their word while STREAM_READY is low.
 */
`timescale 1ns/100ps

module fifo_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire do_wr = wr_valid && wr_ready;
    wire do_rd = rd_valid && rd_ready;

    assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_r != '0);
    assign rd_data = mem_r[rp_r];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge CLK) begin
        if (do_wr) begin
            mem_r[wp_r] <= wr_data;
        end
    end
endmodule

module delay_line #(
    parameter int WIDTH = 9,
    parameter int TAP_W = 4
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic shift_en,
    input wire logic [TAP_W-1:0] tap,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    localparam int DEPTH = 1 << TAP_W;
    logic [WIDTH-1:0] sr_r [DEPTH];

    // Tap zero passes the input straight on, so feeds outside multi-frequency mode cost no delay.
    assign dout = (tap == '0) ? din : sr_r[tap - 1'b1];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < DEPTH; i++) begin
                sr_r[i] <= '0;
            end
        end else if (shift_en) begin
            sr_r[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                sr_r[i] <= sr_r[i-1];
            end
        end
    end
endmodule

module failover_switch #(
    parameter int TICK_CYC = failover_pkg::HOLDOFF_TICK_CYC,
    parameter int DEPTH = failover_pkg::FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic IN1_OK,
    input wire logic IN2_OK,
    input wire logic [failover_pkg::ID_W-1:0] IN1_STREAM_ID,
    input wire logic [failover_pkg::ID_W-1:0] IN2_STREAM_ID,
    input wire logic IN1_SOP,
    input wire logic IN2_SOP,
    input wire failover_pkg::word_t IN1_WORD,
    input wire failover_pkg::word_t IN2_WORD,
    output logic STREAM_READY,
    output failover_pkg::word_t OUT_WORD,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic AUTO_EN,
    input wire failover_pkg::pref_t PREF_SEL,
    input wire logic MANUAL_SEL,
    input wire logic DIRECTION_MODE,
    input wire logic [failover_pkg::HOLD_W-1:0] TO_STANDBY_HOLDOFF,
    input wire logic [failover_pkg::HOLD_W-1:0] SWITCHBACK_HOLDOFF,
    input wire logic SEAMLESS_EN,
    input wire logic MULTI_FREQ_MODE,
    input wire logic [failover_pkg::DLY_W-1:0] MAX_DELAY,
    input wire logic STANDBY_MON_EN,
    output logic ACTIVE_SEL,
    output failover_pkg::auto_state_t AUTO_STATE,
    output logic READY_IND,
    output logic SEAMLESS_OK,
    output logic [failover_pkg::OFS_W-1:0] ARRIVAL_OFFSET,
    output logic EARLY_SEL,
    output logic STANDBY_WARN
);
    localparam int TW = $clog2(TICK_CYC + 1);

    failover_pkg::auto_state_t state_r, state_nxt;
    logic act_r, act_nxt;
    logic [TW-1:0] div_r;
    logic [failover_pkg::HOLD_W-1:0] hold_r;
    logic man_q_r;
    failover_pkg::pref_t pref_q_r;
    logic [failover_pkg::OFS_W-1:0] since1_r, since2_r, ofs_r;
    logic early_r;
    logic warn_r;

    // Decoding of the current situation; inputs arrive on this clock.
    wire tick = (div_r == TW'(TICK_CYC - 1));
    wire ok1 = IN1_OK;
    wire ok2 = IN2_OK;
    wire act_ok = act_r ? ok2 : ok1;
    wire oth_ok = act_r ? ok1 : ok2;
    wire has_pref = (PREF_SEL != failover_pkg::PREF_NONE);
    wire pref_idx = (PREF_SEL == failover_pkg::PREF_IN2);
    wire home_idx = has_pref ? pref_idx : man_q_r;
    wire at_home = (act_r == home_idx);
    wire one_way = (DIRECTION_MODE == failover_pkg::DIR_ONE_WAY);
    wire changed = (state_r == failover_pkg::AUTO_CHANGED);
    wire man_evt = (MANUAL_SEL != man_q_r);
    wire pref_evt = (PREF_SEL != pref_q_r) && has_pref;

    // Seamless changeover needs both feeds, one stream, and in multi-frequency mode enough delay.
    wire ids_same = (IN1_STREAM_ID == IN2_STREAM_ID);
    wire ofs_fits = (ofs_r <= failover_pkg::OFS_W'(MAX_DELAY));
    wire seamless = SEAMLESS_EN && ok1 && ok2 && ids_same &&
                    (!MULTI_FREQ_MODE || ofs_fits);

    // Leaving home uses the to-standby holdoff, returning the switchback one.
    wire want_leave = at_home && !act_ok && oth_ok && !changed;
    // With preference, return on recovery or on standby loss; with both
    // failed this lands on the preferred input and stays there.
    wire want_back_pref = has_pref && !at_home && !one_way &&
                          (oth_ok || !act_ok);
    // Equal priority keeps the new input until it fails as well.
    wire want_back_eq = !has_pref && !at_home && !one_way &&
                        !act_ok && oth_ok;
    wire want = AUTO_EN && (want_leave || want_back_pref || want_back_eq);
    wire [failover_pkg::HOLD_W-1:0] guard =
        want_leave ? TO_STANDBY_HOLDOFF : SWITCHBACK_HOLDOFF;
    wire go = want && (seamless || hold_r >= guard);
    wire man_ok = !has_pref || !at_home;

    always_comb begin
        act_nxt = act_r;
        state_nxt = state_r;
        if (!AUTO_EN) begin
            act_nxt = MANUAL_SEL;
            state_nxt = failover_pkg::AUTO_OFF;
        end else if (pref_evt) begin
            act_nxt = pref_idx;
            state_nxt = failover_pkg::AUTO_ACTIVE;
        end else if (man_evt && man_ok) begin
            act_nxt = MANUAL_SEL;
            // Picking the home input again re-arms a one-way switch.
            if (MANUAL_SEL == home_idx || !has_pref) begin
                state_nxt = failover_pkg::AUTO_ACTIVE;
            end
        end else if (go) begin
            act_nxt = !act_r;
            if (want_leave && one_way) begin
                state_nxt = failover_pkg::AUTO_CHANGED;
            end else begin
                state_nxt = failover_pkg::AUTO_ACTIVE;
            end
        end else if (state_r == failover_pkg::AUTO_OFF) begin
            state_nxt = failover_pkg::AUTO_ACTIVE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= failover_pkg::AUTO_OFF;
            act_r <= failover_pkg::IN_ONE;
            man_q_r <= failover_pkg::IN_ONE;
            pref_q_r <= failover_pkg::PREF_NONE;
        end else begin
            state_r <= state_nxt;
            act_r <= act_nxt;
            man_q_r <= MANUAL_SEL;
            pref_q_r <= PREF_SEL;
        end
    end

    // The holdoff count only grows through an unbroken wish to switch.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_r <= '0;
            hold_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + 1'b1;
            if (!want || go) begin
                hold_r <= '0;
            end else if (tick && hold_r != '1) begin
                hold_r <= hold_r + 1'b1;
            end
        end
    end

    // The offset is the age of the other feed's last packet start, taken
    // when a packet starts; it saturates, so far-apart feeds read as full.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            since1_r <= failover_pkg::OFS_MAX;
            since2_r <= failover_pkg::OFS_MAX;
            ofs_r <= failover_pkg::OFS_MAX;
            early_r <= failover_pkg::IN_ONE;
        end else begin
            since1_r <= IN1_SOP ? failover_pkg::OFS_W'(1'b1) :
                        (since1_r == failover_pkg::OFS_MAX) ? since1_r :
                        since1_r + 1'b1;
            since2_r <= IN2_SOP ? failover_pkg::OFS_W'(1'b1) :
                        (since2_r == failover_pkg::OFS_MAX) ? since2_r :
                        since2_r + 1'b1;
            if (IN2_SOP && !IN1_SOP) begin
                ofs_r <= since1_r;
                early_r <= failover_pkg::IN_ONE;
            end else if (IN1_SOP && !IN2_SOP) begin
                ofs_r <= since2_r;
                early_r <= failover_pkg::IN_TWO;
            end else if (IN1_SOP) begin
                ofs_r <= '0;
            end
        end
    end

    // Earlier feed waits the full max delay, the later one the remainder.
    wire [failover_pkg::DLY_W-1:0] rest = !ofs_fits ? failover_pkg::DLY_ZERO :
        MAX_DELAY - failover_pkg::DLY_W'(ofs_r);
    wire [failover_pkg::DLY_W-1:0] tap1 = !MULTI_FREQ_MODE ?
        failover_pkg::DLY_ZERO : (early_r == failover_pkg::IN_ONE) ?
        MAX_DELAY : rest;
    wire [failover_pkg::DLY_W-1:0] tap2 = !MULTI_FREQ_MODE ?
        failover_pkg::DLY_ZERO : (early_r == failover_pkg::IN_TWO) ?
        MAX_DELAY : rest;

    failover_pkg::word_t dly1, dly2;
    logic fifo_wr_ready;
    logic [failover_pkg::WORD_W-1:0] fifo_rd;

    delay_line #(.WIDTH(failover_pkg::WORD_W), .TAP_W(failover_pkg::DLY_W))
    u_dly1 (
        .CLK(CLK), .ARST_N(ARST_N),
        .shift_en(fifo_wr_ready),
        .tap(tap1),
        .din(IN1_WORD),
        .dout(dly1)
    );

    delay_line #(.WIDTH(failover_pkg::WORD_W), .TAP_W(failover_pkg::DLY_W))
    u_dly2 (
        .CLK(CLK), .ARST_N(ARST_N),
        .shift_en(fifo_wr_ready),
        .tap(tap2),
        .din(IN2_WORD),
        .dout(dly2)
    );

    // A full FIFO stalls the delay lines and, through STREAM_READY, the feeds.
    wire failover_pkg::word_t sel_word = act_r ? dly2 : dly1;

    fifo_buf #(.WIDTH(failover_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .wr_data(sel_word),
        .wr_valid(sel_word.valid),
        .wr_ready(fifo_wr_ready),
        .rd_data(fifo_rd),
        .rd_valid(OUT_VALID),
        .rd_ready(OUT_READY)
    );

    // Standby loss is only reported while monitoring is switched on.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= STANDBY_MON_EN && !oth_ok;
        end
    end

    assign STREAM_READY = fifo_wr_ready;
    assign OUT_WORD = fifo_rd;
    assign ACTIVE_SEL = act_r;
    assign AUTO_STATE = state_r;
    assign READY_IND = (state_r == failover_pkg::AUTO_ACTIVE);
    assign SEAMLESS_OK = seamless;
    assign ARRIVAL_OFFSET = ofs_r;
    assign EARLY_SEL = early_r;
    assign STANDBY_WARN = warn_r;
endmodule

//--- bench/ts_feeds.sv
/*
 * Model of the two stream sources and their packet-start pulses.
 * Assumes the switch takes a word on each edge where ready is high.
 */
`timescale 1ns/100ps
module ts_feeds #(
    parameter int LAG = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic ready,
    output failover_pkg::word_t word1,
    output failover_pkg::word_t word2,
    output logic sop1,
    output logic sop2
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [3:0] ph_r;
    // A source holds its word while the switch cannot take it.
    assign cnt_nxt = (run && ready) ? cnt_r + 8'h01 : cnt_r;
    // Idle data moves every cycle, so a stale word never looks fresh.
    assign word1 = run ? {1'b1, cnt_r} : {1'b0, 4'h0, ph_r};
    assign word2 = word1;
    assign sop1 = ph_r == 4'h0;
    assign sop2 = ph_r == 4'(LAG);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
            ph_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
            ph_r <= ph_r + 4'h1;
        end
    end
endmodule

//--- bench/failover_switch_chk.sv
/*
 * Port assertions of the failover switch.
 * Assumes it is bound to failover_switch with TICK_CYC handed on.
 */
`timescale 1ns/100ps
module failover_chk #(
    parameter int TICK_CYC = 4
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic IN1_OK,
    input wire logic IN2_OK,
    input wire logic [failover_pkg::ID_W-1:0] IN1_STREAM_ID,
    input wire logic [failover_pkg::ID_W-1:0] IN2_STREAM_ID,
    input wire failover_pkg::word_t OUT_WORD,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic AUTO_EN,
    input wire failover_pkg::pref_t PREF_SEL,
    input wire logic MANUAL_SEL,
    input wire logic DIRECTION_MODE,
    input wire logic [failover_pkg::HOLD_W-1:0] TO_STANDBY_HOLDOFF,
    input wire logic SEAMLESS_EN,
    input wire logic STANDBY_MON_EN,
    input wire logic ACTIVE_SEL,
    input wire failover_pkg::auto_state_t AUTO_STATE,
    input wire logic READY_IND,
    input wire logic SEAMLESS_OK,
    input wire logic STANDBY_WARN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic [15:0] fail_cnt_r;
    logic [15:0] fail_cnt_nxt;
    wire logic pref1 = PREF_SEL == failover_pkg::PREF_IN1;
    wire logic on1 = ACTIVE_SEL == failover_pkg::IN_ONE;
    wire logic both = DIRECTION_MODE == failover_pkg::DIR_BOTH;
    // Saturating, so a long outage never wraps back below the holdoff.
    assign fail_cnt_nxt = IN1_OK ? 16'h0000 :
        (&fail_cnt_r ? fail_cnt_r : fail_cnt_r + 16'h0001);
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) fail_cnt_r <= 16'h0000;
        else fail_cnt_r <= fail_cnt_nxt;
    end
    a_off_manual:
    assert property (!AUTO_EN |=> ACTIVE_SEL == $past(MANUAL_SEL) &&
        AUTO_STATE == failover_pkg::AUTO_OFF) else $error("manual lost");
    a_ready_state:
    assert property (READY_IND == (AUTO_STATE == failover_pkg::AUTO_ACTIVE))
        else $error("ready wrong");
    a_holdoff_wait:
    assert property (AUTO_EN && pref1 && $stable(PREF_SEL) && !SEAMLESS_OK &&
        on1 ##1 !on1 |-> 32'(fail_cnt_r) + TICK_CYC >=
        32'(TO_STANDBY_HOLDOFF) * TICK_CYC) else $error("switch early");
    a_seamless_back:
    assert property (AUTO_EN && $stable(AUTO_EN) && pref1 && $stable(PREF_SEL)
        && $stable(MANUAL_SEL) && both && !on1 && IN1_OK && SEAMLESS_EN &&
        SEAMLESS_OK |=> on1) else $error("seamless late");
    a_seamless_none:
    assert property (!IN1_OK || !IN2_OK || IN1_STREAM_ID != IN2_STREAM_ID
        |-> !SEAMLESS_OK) else $error("seamless wrong");
    a_changed_hold:
    assert property (AUTO_EN && $stable(AUTO_EN) && !both &&
        AUTO_STATE == failover_pkg::AUTO_CHANGED && $stable(PREF_SEL) &&
        $stable(MANUAL_SEL) |=> $stable(ACTIVE_SEL)) else $error("returned");
    a_warn_mon:
    assert property (!STANDBY_MON_EN |=> !STANDBY_WARN) else $error("warn");
    a_fifo_hold:
    assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
        $stable(OUT_WORD)) else $error("head lost");
    c_to_standby: cover property (on1 ##1 !on1);
    c_changed: cover property (AUTO_STATE == failover_pkg::AUTO_CHANGED);
    c_warn: cover property (STANDBY_WARN);
    c_seamless: cover property (SEAMLESS_OK && !on1 ##1 on1);
endmodule
bind failover_switch failover_chk #(.TICK_CYC(TICK_CYC)) failover_chk_i (
    .CLK, .ARST_N, .IN1_OK, .IN2_OK, .IN1_STREAM_ID, .IN2_STREAM_ID,
    .OUT_WORD, .OUT_VALID, .OUT_READY, .AUTO_EN, .PREF_SEL, .MANUAL_SEL,
    .DIRECTION_MODE, .TO_STANDBY_HOLDOFF, .SEAMLESS_EN, .STANDBY_MON_EN,
    .ACTIVE_SEL, .AUTO_STATE, .READY_IND, .SEAMLESS_OK, .STANDBY_WARN);

//--- bench/failover_switch_test.sv
/*
 * Self-checking bench of the failover switch, with holdoff ticks of 4 cycles.
 * Assumes the feed model and the checker are compiled before it.
 */
`timescale 1ns/100ps
module failover_switch_test;
    logic CLK = 1'b0, ARST_N = 1'b0, IN1_OK = 1'b1, IN2_OK = 1'b1;
    logic run = 1'b0, OUT_READY = 1'b1, AUTO_EN = 1'b0, MANUAL_SEL = 1'b0;
    logic DIRECTION_MODE = 1'b1, SEAMLESS_EN = 1'b0, MULTI_FREQ_MODE = 1'b0;
    logic STANDBY_MON_EN = 1'b0;
    logic [failover_pkg::ID_W-1:0] IN1_STREAM_ID = 16'h0011;
    logic [failover_pkg::ID_W-1:0] IN2_STREAM_ID = 16'h0022;
    logic [failover_pkg::HOLD_W-1:0] TO_STANDBY_HOLDOFF = 16'h0004;
    logic [failover_pkg::HOLD_W-1:0] SWITCHBACK_HOLDOFF = 16'h0004;
    logic [failover_pkg::DLY_W-1:0] MAX_DELAY = 4'h0;
    failover_pkg::pref_t PREF_SEL = failover_pkg::PREF_NONE;
    failover_pkg::word_t IN1_WORD, IN2_WORD, OUT_WORD;
    failover_pkg::auto_state_t AUTO_STATE;
    logic [failover_pkg::OFS_W-1:0] ARRIVAL_OFFSET;
    logic IN1_SOP, IN2_SOP, STREAM_READY, OUT_VALID, ACTIVE_SEL, READY_IND;
    logic SEAMLESS_OK, EARLY_SEL, STANDBY_WARN;
    int mismatches = 0, comparisons = 0, cycles = 0;
    failover_switch #(.TICK_CYC(4)) failover_switch_i (
        .CLK, .ARST_N, .IN1_OK, .IN2_OK, .IN1_STREAM_ID, .IN2_STREAM_ID,
        .IN1_SOP, .IN2_SOP, .IN1_WORD, .IN2_WORD, .STREAM_READY, .OUT_WORD,
        .OUT_VALID, .OUT_READY, .AUTO_EN, .PREF_SEL, .MANUAL_SEL,
        .DIRECTION_MODE, .TO_STANDBY_HOLDOFF, .SWITCHBACK_HOLDOFF,
        .SEAMLESS_EN, .MULTI_FREQ_MODE, .MAX_DELAY, .STANDBY_MON_EN,
        .ACTIVE_SEL, .AUTO_STATE, .READY_IND, .SEAMLESS_OK, .ARRIVAL_OFFSET,
        .EARLY_SEL, .STANDBY_WARN);
    ts_feeds ts_feeds_i (.clk(CLK), .arst_n(ARST_N), .run(run),
        .ready(STREAM_READY), .word1(IN1_WORD), .word2(IN2_WORD),
        .sop1(IN1_SOP), .sop2(IN2_SOP));
    always #5 CLK = ~CLK;
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The run is short, so a hang is cut off well before it costs time.
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wait_sel(input logic v);
        for (int i = 0; i < 40 && ACTIVE_SEL !== v; i++) tick(1);
        check(ACTIVE_SEL, v);
    endtask
    task automatic t_manual();
        @(posedge CLK);
        MANUAL_SEL <= 1'b1;
        IN2_OK <= 1'b0;
        tick(3);
        check(ACTIVE_SEL, 1'h1);
        check(AUTO_STATE, failover_pkg::AUTO_OFF);
        @(posedge CLK);
        MANUAL_SEL <= 1'b0;
        tick(3);
        check(ACTIVE_SEL, 1'h0);
        $display("manual test done");
    endtask
    task automatic t_failover();
        @(posedge CLK);
        AUTO_EN <= 1'b1;
        PREF_SEL <= failover_pkg::PREF_IN1;
        IN1_OK <= 1'b0;
        tick(24);
        check(ACTIVE_SEL, 1'h0);
        check(READY_IND, 1'h1);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        IN2_OK <= 1'b1;
        @(posedge CLK);
        IN1_OK <= 1'b0;
        tick(8);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        @(posedge CLK);
        IN1_OK <= 1'b0;
        tick(8);
        check(ACTIVE_SEL, 1'h0);
        wait_sel(1'h1);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        tick(8);
        check(ACTIVE_SEL, 1'h1);
        wait_sel(1'h0);
        $display("failover test done");
    endtask
    task automatic t_one_way();
        @(posedge CLK);
        DIRECTION_MODE <= failover_pkg::DIR_ONE_WAY;
        MANUAL_SEL <= 1'b1;
        IN1_OK <= 1'b0;
        tick(3);
        check(ACTIVE_SEL, 1'h0);
        wait_sel(1'h1);
        check(AUTO_STATE, failover_pkg::AUTO_CHANGED);
        check(READY_IND, 1'h0);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        tick(40);
        check(ACTIVE_SEL, 1'h1);
        @(posedge CLK);
        MANUAL_SEL <= 1'b0;
        tick(3);
        check(ACTIVE_SEL, 1'h0);
        check(AUTO_STATE, failover_pkg::AUTO_ACTIVE);
        $display("one-way test done");
    endtask
    task automatic t_seamless();
        @(posedge CLK);
        DIRECTION_MODE <= failover_pkg::DIR_BOTH;
        SEAMLESS_EN <= 1'b1;
        IN2_STREAM_ID <= 16'h0011;
        SWITCHBACK_HOLDOFF <= 16'h0064;
        IN1_OK <= 1'b0;
        wait_sel(1'h1);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        tick(2);
        check(ACTIVE_SEL, 1'h0);
        check(SEAMLESS_OK, 1'h1);
        @(posedge CLK);
        MULTI_FREQ_MODE <= 1'b1;
        MAX_DELAY <= 4'h1;
        tick(20);
        check(SEAMLESS_OK, 1'h0);
        @(posedge CLK);
        MAX_DELAY <= 4'h8;
        tick(20);
        check(SEAMLESS_OK, 1'h1);
        @(posedge CLK);
        IN2_STREAM_ID <= 16'h0022;
        tick(2);
        check(SEAMLESS_OK, 1'h0);
        $display("seamless test done");
    endtask
    task automatic t_equal();
        @(posedge CLK);
        PREF_SEL <= failover_pkg::PREF_NONE;
        SWITCHBACK_HOLDOFF <= 16'h0004;
        IN2_OK <= 1'b1;
        IN1_OK <= 1'b0;
        wait_sel(1'h1);
        @(posedge CLK);
        IN1_OK <= 1'b1;
        tick(40);
        check(ACTIVE_SEL, 1'h1);
        @(posedge CLK);
        IN2_OK <= 1'b0;
        tick(8);
        check(ACTIVE_SEL, 1'h1);
        wait_sel(1'h0);
        @(posedge CLK);
        IN2_OK <= 1'b1;
        MANUAL_SEL <= 1'b1;
        tick(3);
        check(ACTIVE_SEL, 1'h1);
        $display("equal priority test done");
    endtask
    task automatic t_stream();
        logic [7:0] exp;
        int n;
        exp = 8'h00;
        n = 0;
        @(posedge CLK);
        MULTI_FREQ_MODE <= 1'b0;
        OUT_READY <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < 60 && STREAM_READY !== 1'b0; i++) tick(1);
        check(STREAM_READY, 0);
        @(posedge CLK);
        run <= 1'b0;
        OUT_READY <= 1'b1;
        // Look at the head before the first pop, so word zero is judged too.
        #1;
        while (OUT_VALID === 1'b1 && n < 40) begin
            check(OUT_WORD.data, exp);
            exp++;
            n++;
            tick(1);
        end
        check(16'(n), 16'(failover_pkg::FIFO_DEPTH));
        $display("fifo test done");
    endtask
    task automatic t_offset_warn();
        check(ARRIVAL_OFFSET, 8'h03);
        check(EARLY_SEL, 1'h0);
        @(posedge CLK);
        STANDBY_MON_EN <= 1'b1;
        IN2_OK <= 1'b0;
        tick(3);
        check(STANDBY_WARN, 1'h1);
        @(posedge CLK);
        STANDBY_MON_EN <= 1'b0;
        tick(3);
        check(STANDBY_WARN, 1'h0);
        $display("offset and warning test done");
    endtask
    initial begin
        tick(10);
        check(ARRIVAL_OFFSET, 8'hFF);
        check({OUT_VALID, STREAM_READY, ACTIVE_SEL}, 3'h2);
        @(posedge CLK);
        ARST_N <= 1'b1;
        t_manual();
        t_failover();
        t_one_way();
        t_seamless();
        t_stream();
        t_offset_warn();
        t_equal();
        finish_test();
    end
endmodule
